/* rtl/sdm_mode_reg.sv */
module sdm_mode_reg #(
    parameter int ROW_W = 13,
    parameter int COL_W = 10,
    parameter int DLL_LOCK_CYC = 200
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [ROW_W-1:0] addr,
    output logic [ROW_W-1:0] mode_reg,
    output logic [ROW_W-1:0] ext_mode1_reg,
    output logic [ROW_W-1:0] ext_mode2_reg,
    output logic [ROW_W-1:0] ext_mode3_reg,
    output logic dll_reset_pulse,
    output logic dll_locked,
    output logic [1:0] open_bank,
    output logic [ROW_W-1:0] open_row,
    output logic burst_active,
    output logic burst_write,
    output logic [COL_W-1:0] burst_col,
    output logic auto_precharge,
    output logic [2:0] cas_latency,
    output logic [2:0] write_recovery
);
    typedef enum logic [1:0] {
        SDM_IDLE = 2'b01,
        SDM_BURST = 2'b10
    } sdm_state_t;

    localparam logic [7:0] LOCK_CNT = 8'(DLL_LOCK_CYC);

    logic [3:0] cmd;
    logic mr_wr, act, rd, wr;
    logic [ROW_W-1:0] mr_next, emr1_next, emr2_next, emr3_next;
    logic [1:0] bank_next;
    logic [ROW_W-1:0] row_next;
    logic [7:0] lock_reg, lock_next;
    logic locked_reg, locked_next, dllp_next;
    sdm_state_t state_reg, state_next;
    logic [2:0] beat_reg, beat_next;
    logic [COL_W-1:0] start_reg, start_next;
    logic write_reg, write_next, ap_reg, ap_next;
    logic eight_reg, eight_next, il_reg, il_next;
    logic [COL_W-1:0] col_w;
    logic [2:0] last_beat;

    assign cmd = {cs_n, ras_n, cas_n, we_n};
    // commands count only when clock enable is high
    assign mr_wr = cke && (cmd == sdm_pkg::CMD_MRW);
    assign act = cke && (cmd == sdm_pkg::CMD_ACT);
    assign rd = cke && (cmd == sdm_pkg::CMD_RD);
    assign wr = cke && (cmd == sdm_pkg::CMD_WR);

    always_comb
    begin
        mr_next = mode_reg;
        emr1_next = ext_mode1_reg;
        emr2_next = ext_mode2_reg;
        emr3_next = ext_mode3_reg;
        dllp_next = 1'b0;
        // whole word replaced, no partial update; array untouched
        if (mr_wr && ba == sdm_pkg::BA_MR)
        begin
            mr_next = addr;
            dllp_next = addr[sdm_pkg::DLLR_BIT];
        end
        else if (mr_wr && ba == sdm_pkg::BA_EMR1)
        begin
            emr1_next = addr;
        end
        else if (mr_wr && ba == sdm_pkg::BA_EMR2)
        begin
            emr2_next = addr;
        end
        else if (mr_wr && ba == sdm_pkg::BA_EMR3)
        begin
            emr3_next = addr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mode_reg <= sdm_pkg::MR_RESET;
            ext_mode1_reg <= sdm_pkg::EMR_RESET;
            ext_mode2_reg <= sdm_pkg::EMR_RESET;
            ext_mode3_reg <= sdm_pkg::EMR_RESET;
            dll_reset_pulse <= 1'b0;
        end
        else
        begin
            mode_reg <= mr_next;
            ext_mode1_reg <= emr1_next;
            ext_mode2_reg <= emr2_next;
            ext_mode3_reg <= emr3_next;
            dll_reset_pulse <= dllp_next;
        end
    end

    // lock counter restarts on each dll reset write
    always_comb
    begin
        lock_next = lock_reg;
        locked_next = locked_reg;
        if (dllp_next)
        begin
            lock_next = LOCK_CNT;
            locked_next = 1'b0;
        end
        else if (lock_reg != 8'h00)
        begin
            lock_next = lock_reg - 8'h01;
            locked_next = (lock_reg == 8'h01);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            lock_reg <= 8'h00;
            locked_reg <= 1'b0;
        end
        else
        begin
            lock_reg <= lock_next;
            locked_reg <= locked_next;
        end
    end
    assign dll_locked = locked_reg;

    // whole-cycle latency only; half-cycle codes do not exist here
    assign cas_latency = mode_reg[sdm_pkg::CL_LSB +: 3];
    assign write_recovery = mode_reg[sdm_pkg::WR_LSB +: 3];

    always_comb
    begin
        bank_next = open_bank;
        row_next = open_row;
        if (act)
        begin
            bank_next = ba;
            row_next = addr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            open_bank <= 2'h0;
            open_row <= '0;
        end
        else
        begin
            open_bank <= bank_next;
            open_row <= row_next;
        end
    end

    assign last_beat = eight_reg ? 3'h7 : 3'h3;

    always_comb
    begin
        state_next = state_reg;
        beat_next = beat_reg;
        start_next = start_reg;
        write_next = write_reg;
        ap_next = ap_reg;
        eight_next = eight_reg;
        il_next = il_reg;
        case (state_reg)
            SDM_IDLE:
            begin
                if (rd || wr)
                begin
                    state_next = SDM_BURST;
                    beat_next = 3'h0;
                    start_next = addr[COL_W-1:0];
                    ap_next = addr[sdm_pkg::AP_BIT];
                    write_next = wr;
                    eight_next = (mode_reg[sdm_pkg::BL_LSB +: 3]
                                  == sdm_pkg::BL_EIGHT);
                    il_next = mode_reg[sdm_pkg::BT_BIT];
                end
            end
            SDM_BURST:
            begin
                if (beat_reg == last_beat)
                begin
                    state_next = SDM_IDLE;
                end
                else
                begin
                    beat_next = beat_reg + 3'h1;
                end
            end
            default:
            begin
                state_next = SDM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= SDM_IDLE;
            beat_reg <= 3'h0;
            start_reg <= '0;
            write_reg <= 1'b0;
            ap_reg <= 1'b0;
            eight_reg <= 1'b0;
            il_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            beat_reg <= beat_next;
            start_reg <= start_next;
            write_reg <= write_next;
            ap_reg <= ap_next;
            eight_reg <= eight_next;
            il_reg <= il_next;
        end
    end

    sdm_burst_seq #(.COL_W(COL_W)) u_seq (
        .start_col(start_reg),
        .interleave(il_reg),
        .eight(eight_reg),
        .beat(beat_reg),
        .col(col_w)
    );

    assign burst_active = (state_reg == SDM_BURST);
    assign burst_write = write_reg;
    assign burst_col = col_w;
    assign auto_precharge = ap_reg;

    a_mr_capture: assert property (@(posedge clk) disable iff (reset)
        mr_wr && ba == sdm_pkg::BA_MR |=> mode_reg == $past(addr))
        else $error("mode register not captured");
    a_emr2_capture: assert property (@(posedge clk) disable iff (reset)
        mr_wr && ba == sdm_pkg::BA_EMR2 |=> ext_mode2_reg == $past(addr))
        else $error("extended register 2 not captured");
    a_lock_wait: assert property (@(posedge clk) disable iff (reset)
        dll_reset_pulse |-> !dll_locked [*8])
        else $error("dll locked too early");
    a_lock_done: assert property (@(posedge clk) disable iff (reset)
        dll_reset_pulse
        |-> ##[1:DLL_LOCK_CYC] (dll_locked || dll_reset_pulse))
        else $error("dll lock not reached");
    a_row_open: assert property (@(posedge clk) disable iff (reset)
        act |=> open_row == $past(addr) && open_bank == $past(ba))
        else $error("active row not latched");
    a_burst_len: assert property (@(posedge clk) disable iff (reset)
        $rose(burst_active) && !eight_reg |-> burst_active [*4]
        ##1 !burst_active)
        else $error("burst of four wrong length");
    a_burst_start: assert property (@(posedge clk) disable iff (reset)
        $rose(burst_active) |-> burst_col == $past(addr[COL_W-1:0]))
        else $error("burst does not start at column");
    a_ap_flag: assert property (@(posedge clk) disable iff (reset)
        (rd || wr) && !burst_active
        |=> auto_precharge == $past(addr[sdm_pkg::AP_BIT]))
        else $error("auto precharge flag lost");
    c_mr_write: cover property (@(posedge clk) mr_wr);
    c_dll_lock: cover property (@(posedge clk) $rose(dll_locked));
    c_burst8: cover property (@(posedge clk) burst_active && eight_reg);
endmodule

/* rtl/sdm_pkg.sv */
package sdm_pkg;
    // command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRW = 4'h0;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [1:0] BA_MR = 2'h0;
    localparam logic [1:0] BA_EMR1 = 2'h1;
    localparam logic [1:0] BA_EMR2 = 2'h2;
    localparam logic [1:0] BA_EMR3 = 2'h3;
    // mode register field positions; AP_BIT is the column address bit for auto precharge
    localparam int BL_LSB = 0;
    localparam int BT_BIT = 3;
    localparam int CL_LSB = 4;
    localparam int TM_BIT = 7;
    localparam int DLLR_BIT = 8;
    localparam int WR_LSB = 9;
    localparam int AP_BIT = 10;
    localparam logic [2:0] BL_FOUR = 3'h2;
    localparam logic [2:0] BL_EIGHT = 3'h3;
    localparam logic [3:0] BEATS_FOUR = 4'h4;
    localparam logic [3:0] BEATS_EIGHT = 4'h8;
    localparam logic [12:0] MR_RESET = 13'h0000;
    localparam logic [12:0] EMR_RESET = 13'h0000;
endpackage

/* rtl/sdm_burst_seq.sv */
module sdm_burst_seq #(
    parameter int COL_W = 10
) (
    input wire logic [COL_W-1:0] start_col,
    input wire logic interleave,
    input wire logic eight,
    input wire logic [2:0] beat,
    output logic [COL_W-1:0] col
);
    logic [2:0] low;
    always_comb
    begin
        // wrap inside the aligned 4 or 8 block, sequential or interleaved
        if (interleave)
        begin
            low = start_col[2:0] ^ beat;
        end
        else
        begin
            low = start_col[2:0] + beat;
        end
        if (eight)
        begin
            col = {start_col[COL_W-1:3], low};
        end
        else
        begin
            col = {start_col[COL_W-1:2], low[1:0]};
        end
    end
endmodule

/* bench/sdm_ctrl_model.sv */
module sdm_ctrl_model
(
    input wire logic clk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic [12:0] addr
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] cmd_pre = 4'h2;
    localparam logic [3:0] cmd_ref = 4'h1;
    initial
    begin
        cke = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = 2'h0;
        addr = 13'h0000;
    end
    task automatic set_cke(input logic v);
        @(negedge clk);
        cke = v;
    endtask
    task automatic cmd(input logic [3:0] c, input logic [1:0] b,
        input logic [12:0] a);
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        // lines are don't-care now; never leave the old value
        ba = ~b;
        addr = ~a;
    endtask
    task automatic power_up(input int wait_cyc, input logic [12:0] mode);
        repeat (wait_cyc) @(negedge clk);
        cke = 1'b1;
        repeat (8) @(negedge clk);
        cmd(cmd_pre, 2'h0, 13'h0400);
        cmd(sdm_pkg::CMD_MRW, sdm_pkg::BA_EMR2, 13'h0080);
        cmd(sdm_pkg::CMD_MRW, sdm_pkg::BA_EMR3, 13'h0000);
        cmd(sdm_pkg::CMD_MRW, sdm_pkg::BA_EMR1, 13'h0044);
        cmd(sdm_pkg::CMD_MRW, sdm_pkg::BA_MR, mode | 13'h0100);
    endtask
    task automatic settle(input logic [12:0] mode);
        cmd(cmd_pre, 2'h0, 13'h0400);
        cmd(cmd_ref, 2'h0, 13'h0000);
        cmd(cmd_ref, 2'h0, 13'h0000);
        repeat (200) @(negedge clk);
        cmd(sdm_pkg::CMD_MRW, sdm_pkg::BA_MR, mode);
        cmd(sdm_pkg::CMD_MRW, sdm_pkg::BA_EMR1, 13'h03c4);
        cmd(sdm_pkg::CMD_MRW, sdm_pkg::BA_EMR1, 13'h0044);
    endtask
    task automatic precharge();
        cmd(cmd_pre, 2'h0, 13'h0400);
    endtask
endmodule

/* bench/sdm_mode_reg_tb_top.sv */
module sdm_mode_reg_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LOCK = 10;
    // bl8 interleaved cl3 wr4, then bl4 sequential cl3 wr4
    localparam logic [12:0] MODE8 = 13'h083b;
    localparam logic [12:0] MODE4 = 13'h0832;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cke, cs_n, ras_n, cas_n, we_n, pulse, locked, act, wr, ap;
    logic [1:0] ba, bank;
    logic [12:0] addr, mr, e1, e2, e3, row;
    logic [9:0] col;
    logic [2:0] cl, wrc;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    initial
    begin
        forever #25 clk = ~clk;
    end
    sdm_ctrl_model model (.clk(clk), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
    sdm_mode_reg #(.DLL_LOCK_CYC(LOCK)) DUT (.clk(clk), .reset(reset),
        .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .mode_reg(mr),
        .ext_mode1_reg(e1), .ext_mode2_reg(e2), .ext_mode3_reg(e3),
        .dll_reset_pulse(pulse), .dll_locked(locked), .open_bank(bank),
        .open_row(row), .burst_active(act), .burst_write(wr),
        .burst_col(col), .auto_precharge(ap), .cas_latency(cl),
        .write_recovery(wrc));
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk_word(input logic [12:0] got, input logic [12:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({12'h000, got}, {12'h000, exp});
    endtask
    // one beat per cycle, checked at the falling edge
    task automatic chk_burst(input logic [9:0] c0, input logic il,
        input int n, input logic w);
        logic [9:0] m;
        logic [9:0] c;
        m = 10'(n - 1);
        for (int i = 0; i < n; i++)
        begin
            c = il ? (c0 ^ 10'(i)) : ((c0 & ~m) | ((c0 + 10'(i)) & m));
            chk_bit(act, 1'b1);
            chk_word({3'h0, col}, {3'h0, c});
            chk_bit(wr, w);
            @(negedge clk);
        end
        chk_bit(act, 1'b0);
    endtask
    initial
    begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        chk_word(mr, 13'h0000);
        chk_bit(locked, 1'b0);
        $display("test reset done");
        model.power_up(4000, MODE8);
        chk_bit(pulse, 1'b1);
        repeat (8) @(negedge clk);
        chk_bit(locked, 1'b0);
        repeat (2) @(negedge clk);
        chk_bit(locked, 1'b1);
        chk_word(e2, 13'h0080);
        chk_word(e3, 13'h0000);
        model.settle(MODE8);
        chk_word(mr, MODE8);
        chk_word(e1, 13'h0044);
        chk_word({10'h0, cl}, 13'h0003);
        chk_word({10'h0, wrc}, 13'h0004);
        $display("test init done");
        model.cmd(sdm_pkg::CMD_ACT, 2'h2, 13'h1abc);
        chk_word({11'h0, bank}, 13'h0002);
        chk_word(row, 13'h1abc);
        model.cmd(sdm_pkg::CMD_WR, 2'h2, 13'h0005);
        chk_bit(ap, 1'b0);
        chk_burst(10'h005, 1'b1, 8, 1'b1);
        $display("test bl8 done");
        model.precharge();
        model.cmd(sdm_pkg::CMD_MRW, sdm_pkg::BA_MR, MODE4);
        chk_word(mr, MODE4);
        chk_word(row, 13'h1abc);
        model.cmd(sdm_pkg::CMD_RD, 2'h1, 13'h0406);
        chk_bit(ap, 1'b1);
        fork
            chk_burst(10'h006, 1'b0, 4, 1'b0);
            model.cmd(sdm_pkg::CMD_WR, 2'h1, 13'h0001);
        join
        $display("test bl4 done");
        model.set_cke(1'b0);
        model.cmd(sdm_pkg::CMD_MRW, sdm_pkg::BA_MR, 13'h0000);
        chk_word(mr, MODE4);
        model.set_cke(1'b1);
        $display("test cke done");
        // mid-run reset must bring the stored words back to zero
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk_word(mr, 13'h0000);
        chk_word(e1, 13'h0000);
        chk_bit(locked, 1'b0);
        $display("test reset again done");
        give_verdict();
    end
endmodule
